/* File: src/gpt_top.sv */
// Module: general purpose timer with counter, encoder, trigger and channels
`timescale 1ns/1ns
`default_nettype none
module gpt_top
#(
    parameter logic [1:0] VARIANT = gpt_pkg::GPT_VAR_FULL
)
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Configuration
    input wire logic cnt_en,
    input wire logic dir_down,
    input wire logic [15:0] psc_val,
    input wire logic [15:0] arr_val,
    input wire gpt_pkg::gpt_src_t src_sel,
    input wire logic dbg_freeze_en,
    input wire logic dbg_halt,
    input wire logic dma_en,
    input wire logic [7:0] ch_mode,
    input wire logic [63:0] ch_cmp,
    // Pins
    input wire logic lse_in,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic [2:0] hall_in,
    input wire logic [3:0] cap_pin,
    input wire logic trig_in,
    // Results
    output logic [15:0] cnt_out,
    output logic [3:0] ch_out,
    output logic [63:0] cap_out,
    output logic update_evt,
    output logic trig_out,
    output logic dac_trig,
    output logic dma_req,
    output logic hall_evt
);
    import gpt_pkg::*;
    localparam int NCH = (VARIANT == GPT_VAR_FULL) ? 4 :
                         (VARIANT == GPT_VAR_DUAL) ? 2 :
                         (VARIANT == GPT_VAR_SINGLE) ? 1 : 0;
    localparam int PINS = 10;

    // Three-stage synchronisers for all pins
    logic [PINS-1:0] s1_r;
    logic [PINS-1:0] s2_r;
    logic [PINS-1:0] s3_r;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else if (ce)
        begin
            s1_r <= {trig_in, cap_pin, hall_in, enc_b, enc_a};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // A change counts once stages two and three agree
    logic [PINS-1:0] pin_r;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pin_r <= '0;
        else if (ce)
        begin
            for (int i = 0; i < PINS; i++)
                if (s2_r[i] == s3_r[i])
                    pin_r[i] <= s3_r[i];
        end
    end
    logic a_q;
    logic b_q;
    logic [2:0] hall_q;
    logic [3:0] cap_q;
    logic trg_q;
    assign a_q = pin_r[0];
    assign b_q = pin_r[1];
    assign hall_q = pin_r[4:2];
    assign cap_q = pin_r[8:5];
    assign trg_q = pin_r[9];

    // Low-speed clock pin: three stages plus agree, like the other pins; it is slow enough
    // that the extra latency costs nothing
    logic lse1_r;
    logic lse2_r;
    logic lse3_r;
    logic lse_r;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lse1_r <= 1'b0;
            lse2_r <= 1'b0;
            lse3_r <= 1'b0;
            lse_r <= 1'b0;
        end
        else if (ce)
        begin
            lse1_r <= lse_in;
            lse2_r <= lse1_r;
            lse3_r <= lse2_r;
            if (lse2_r == lse3_r)
                lse_r <= lse3_r;
        end
    end

    // Previous values for edge detection
    logic a_d_r;
    logic b_d_r;
    logic lse_d_r;
    logic trg_d_r;
    logic [2:0] hall_d_r;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            a_d_r <= 1'b0;
            b_d_r <= 1'b0;
            lse_d_r <= 1'b0;
            trg_d_r <= 1'b0;
            hall_d_r <= 3'h0;
        end
        else if (ce)
        begin
            a_d_r <= a_q;
            b_d_r <= b_q;
            lse_d_r <= lse_r;
            trg_d_r <= trg_q;
            hall_d_r <= hall_q;
        end
    end

    // Encoder: x4 decode from synchronised phases
    logic enc_step;
    logic enc_dn;
    assign enc_step = (a_q ^ a_d_r) ^ (b_q ^ b_d_r); // RULE_06
    assign enc_dn = a_q ^ b_d_r; // RULE_06

    // Tick source; reduced variants may run off the low-speed clock
    logic tick;
    logic tick_dn;
    always_comb
    begin
        tick = 1'b0;
        tick_dn = dir_down && VARIANT != GPT_VAR_SINGLE; // RULE_07
        case (src_sel)
            GPT_SRC_INT: tick = 1'b1;
            GPT_SRC_LSE: tick = (VARIANT != GPT_VAR_FULL) && lse_r && !lse_d_r; // RULE_08
            GPT_SRC_ENC:
            begin
                tick = (VARIANT == GPT_VAR_FULL) && enc_step;
                tick_dn = enc_dn;
            end
            GPT_SRC_TRG: tick = trg_q && !trg_d_r; // RULE_03
            default: tick = 1'b0;
        endcase
    end

    // Prescaler and counter; debug halt freezes both when dbg_freeze_en is set
    logic run;
    assign run = ce && cnt_en && !(dbg_freeze_en && dbg_halt); // RULE_04
    logic [15:0] psc_r;
    logic [15:0] cnt_r;
    logic upd_r;
    logic psc_hit;
    // At or above, so a smaller divider set mid-count wraps at once instead of going round 64K
    assign psc_hit = tick && (psc_r >= psc_val); // RULE_01
    always_ff @(posedge core_clk)
    begin
        if (rst)
            psc_r <= GPT_PSC_RST;
        else if (run && tick)
            psc_r <= psc_hit ? 16'h0000 : psc_r + 16'h0001; // RULE_01
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_r <= GPT_CNT_RST;
            upd_r <= 1'b0;
        end
        else if (ce)
        begin
            upd_r <= 1'b0;
            if (run && psc_hit)
            begin
                if (!tick_dn)
                begin
                    if (cnt_r >= arr_val)
                    begin
                        cnt_r <= 16'h0000; // RULE_10
                        upd_r <= 1'b1;
                    end
                    else
                        cnt_r <= cnt_r + 16'h0001; // RULE_01
                end
                else if (cnt_r == 16'h0000)
                begin
                    cnt_r <= arr_val; // RULE_10
                    upd_r <= 1'b1;
                end
                else
                    cnt_r <= cnt_r - 16'h0001; // RULE_01
            end
        end
    end

    // Channels
    logic [3:0] ch_o;
    logic [3:0] cap_e;
    logic [3:0] cmp_e;
    logic [63:0] cap_v;
    genvar g;
    generate
        for (g = 0; g < GPT_MAXCH; g++)
        begin : g_ch
            if (g < NCH)
            begin : g_on
                gpt_chan_if cif ();
                assign cif.cnt = cnt_r;
                assign cif.arr = arr_val;
                assign cif.upd = upd_r;
                assign cif.en = cnt_en;
                assign cif.mode = ch_mode[2*g +: 2];
                assign cif.cmp = ch_cmp[16*g +: 16];
                assign cif.cap_in = cap_q[g];
                gpt_chan u_ch (.core_clk(core_clk), .rst(rst), .ce(ce), .c(cif)); // RULE_02
                assign ch_o[g] = cif.out;
                assign cap_e[g] = cif.cap_evt;
                assign cmp_e[g] = cif.cmp_evt;
                assign cap_v[16*g +: 16] = cif.cap_val;
            end
            else
            begin : g_off
                assign ch_o[g] = 1'b0; // RULE_09
                assign cap_e[g] = 1'b0;
                assign cmp_e[g] = 1'b0;
                assign cap_v[16*g +: 16] = 16'h0000;
            end
        end
    endgenerate

    // Registered outputs
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_out <= GPT_CNT_RST;
            ch_out <= 4'h0;
            cap_out <= 64'h0;
            update_evt <= 1'b0;
            trig_out <= 1'b0;
            dac_trig <= 1'b0;
            dma_req <= 1'b0;
            hall_evt <= 1'b0;
        end
        else if (ce)
        begin
            cnt_out <= cnt_r;
            ch_out <= ch_o;
            cap_out <= cap_v;
            update_evt <= upd_r; // RULE_10
            trig_out <= upd_r; // RULE_03
            dac_trig <= upd_r && VARIANT == GPT_VAR_BASIC; // RULE_09
            dma_req <= dma_en && VARIANT == GPT_VAR_FULL && (upd_r || |cap_e || |cmp_e); // RULE_05
            hall_evt <= VARIANT == GPT_VAR_FULL && (hall_q != hall_d_r); // RULE_06
        end
    end
endmodule
`default_nettype wire

/* File: src/gpt_pkg.sv */
// Package: constants and types for the general purpose timer
// Contract
// RULE_01: The counter is 16 bits, auto-reloading, counts up or down, fed by a 16-bit prescaler.
// RULE_02: The full variant has four channels, each capture, compare, PWM or one-pulse.
// RULE_03: Trigger signals go to and come from sibling timers for sync and event chaining.
// RULE_04: The counter holds its value while the processor is halted in debug, if selected.
// RULE_05: Each full timer raises its own DMA requests.
// RULE_06: Quadrature encoder inputs move the counter; one to three hall inputs are accepted.
// RULE_07: Variant one has one channel and up-only count; variant two has two channels, up/down.
// RULE_08: Reduced variants can be clocked from the low-speed external clock as time bases.
// RULE_09: The basic variant has no channels and its periodic event triggers the DAC.
// RULE_10: Overflow or underflow reloads the counter and signals an update event.
package gpt_pkg;
    localparam int GPT_W = 16;
    localparam int GPT_MAXCH = 4;
    localparam logic [15:0] GPT_ARR_RST = 16'hFFFF;
    localparam logic [15:0] GPT_PSC_RST = 16'h0000;
    localparam logic [15:0] GPT_CNT_RST = 16'h0000;
    // Variant selector
    localparam logic [1:0] GPT_VAR_FULL = 2'h0;
    localparam logic [1:0] GPT_VAR_DUAL = 2'h1;
    localparam logic [1:0] GPT_VAR_SINGLE = 2'h2;
    localparam logic [1:0] GPT_VAR_BASIC = 2'h3;
    // Channel modes
    typedef enum logic [3:0] {
        GPT_CH_CAPTURE = 4'b0001,
        GPT_CH_COMPARE = 4'b0010,
        GPT_CH_PWM = 4'b0100,
        GPT_CH_ONEPULSE = 4'b1000
    } gpt_chmode_t;
    // Counter source modes
    typedef enum logic [3:0] {
        GPT_SRC_INT = 4'b0001,
        GPT_SRC_LSE = 4'b0010,
        GPT_SRC_ENC = 4'b0100,
        GPT_SRC_TRG = 4'b1000
    } gpt_src_t;
endpackage

/* File: src/gpt_chan_if.sv */
// Interface: counter state shared with the channel unit
`timescale 1ns/1ns
`default_nettype none
interface gpt_chan_if;
    logic [15:0] cnt;
    logic [15:0] arr;
    logic upd;
    logic en;
    logic [1:0] mode;
    logic [15:0] cmp;
    logic cap_in;
    logic out;
    logic cap_evt;
    logic cmp_evt;
    logic [15:0] cap_val;
    modport top (output cnt, arr, upd, en, mode, cmp, cap_in,
                 input out, cap_evt, cmp_evt, cap_val);
    modport ch (input cnt, arr, upd, en, mode, cmp, cap_in,
                output out, cap_evt, cmp_evt, cap_val);
endinterface
`default_nettype wire

/* File: src/gpt_chan.sv */
// Module: one capture/compare channel
`timescale 1ns/1ns
`default_nettype none
module gpt_chan
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Counter side
    gpt_chan_if.ch c
);
    import gpt_pkg::*;
    logic cap_d_r;
    logic op_done_r;
    logic out_r;
    logic cap_evt_r;
    logic cmp_evt_r;
    logic [15:0] cap_val_r;
    logic hit;
    assign hit = (c.cnt == c.cmp);
    assign c.out = out_r;
    assign c.cap_evt = cap_evt_r;
    assign c.cmp_evt = cmp_evt_r;
    assign c.cap_val = cap_val_r;
    // Capture on rising edge of the (already synchronised) input
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cap_d_r <= 1'b0;
            cap_evt_r <= 1'b0;
            cap_val_r <= 16'h0000;
        end
        else if (ce)
        begin
            cap_d_r <= c.cap_in;
            cap_evt_r <= 1'b0;
            if (c.en && c.mode == 2'h0 && c.cap_in && !cap_d_r)
            begin
                cap_val_r <= c.cnt; // RULE_02
                cap_evt_r <= 1'b1;
            end
        end
    end
    // Output waveform: toggle, PWM level, or one pulse that stops after a period
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            out_r <= 1'b0;
            cmp_evt_r <= 1'b0;
            op_done_r <= 1'b0;
        end
        else if (ce)
        begin
            cmp_evt_r <= c.en && c.mode != 2'h0 && hit;
            if (!c.en)
                op_done_r <= 1'b0;
            case (c.mode)
                2'h1: if (c.en && hit) out_r <= !out_r; // RULE_02
                2'h2: out_r <= c.en && (c.cnt < c.cmp); // RULE_02
                2'h3:
                begin
                    out_r <= c.en && !op_done_r && (c.cnt >= c.cmp); // RULE_02
                    if (c.en && c.upd)
                        op_done_r <= 1'b1;
                end
                default: out_r <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: verif/gpt_enc_model.sv */
// Model: shaft with a quadrature encoder and three hall sensors
`timescale 1ns/1ns
`default_nettype none
module gpt_enc_model
(
    // Step command
    input wire logic core_clk,
    input wire logic step,
    input wire logic back,
    // Sensor levels
    output logic enc_a,
    output logic enc_b,
    output logic [2:0] hall
);
    logic [1:0] q_r = 2'h0;
    logic [2:0] h_r = 3'h0;
    // Gray phase and Johnson hall code, so only one line changes per step
    always @(posedge core_clk)
    begin
        if (step)
        begin
            q_r <= back ? q_r - 2'h1 : q_r + 2'h1;
            h_r <= back ? {~h_r[0], h_r[2:1]} : {h_r[1:0], ~h_r[2]};
        end
    end
    // Sensors hold their level between steps
    assign enc_a = q_r[1];
    assign enc_b = q_r[1] ^ q_r[0];
    assign hall = h_r;
endmodule
`default_nettype wire

/* File: verif/gpt_top_checker.sv */
// Checker: port-level rules of the timer
`timescale 1ns/1ns
`default_nettype none
module gpt_top_checker
#(
    parameter logic [1:0] VARIANT = 2'h0
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched ports
    input wire logic ce,
    input wire logic cnt_en,
    input wire logic dbg_freeze_en,
    input wire logic dbg_halt,
    input wire logic dma_en,
    input wire logic [15:0] arr_val,
    input wire logic [15:0] cnt_out,
    input wire logic [3:0] ch_out,
    input wire logic update_evt,
    input wire logic dac_trig,
    input wire logic dma_req
);
    import gpt_pkg::*;
    localparam int NCH = (VARIANT == GPT_VAR_FULL) ? 4 : (VARIANT == GPT_VAR_DUAL) ? 2
        : (VARIANT == GPT_VAR_SINGLE) ? 1 : 0;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    // Two held edges cover the one-cycle lag of the count output
    AST_IDLE_HOLD:
    assert property (!$past(rst) && !$past(rst, 2) && !$past(cnt_en) && !$past(cnt_en, 2)
        |-> $stable(cnt_out)) else $error("count moved while disabled");
    AST_CE_HOLD:
    assert property (!$past(rst) && !$past(ce) |-> $stable(cnt_out))
        else $error("count moved with clock enable low");
    AST_DEBUG_HOLD:
    assert property (!$past(rst) && !$past(rst, 2) && $past(dbg_freeze_en && dbg_halt)
        && $past(dbg_freeze_en && dbg_halt, 2) |-> $stable(cnt_out))
        else $error("count moved in debug halt");
    AST_UPD_AT_BOUND:
    assert property (update_evt && !$past(rst) && $stable(arr_val) && $past(arr_val, 2) == arr_val
        |-> $past(cnt_out) == 16'h0000 || $past(cnt_out) == arr_val)
        else $error("update without wrap");
    AST_DAC_BASIC:
    assert property (dac_trig |-> VARIANT == GPT_VAR_BASIC) else $error("dac trigger on variant");
    AST_DMA_QUIET:
    assert property (!$past(rst) && $past(ce) && !$past(dma_en) && !$past(dma_en, 2)
        && !$past(dma_en, 3) |-> !dma_req) else $error("dma request while disabled");
    AST_CH_COUNT:
    assert property ((ch_out >> NCH) == 4'h0) else $error("missing channel drives output");
    AST_SINGLE_UP:
    assert property (VARIANT == GPT_VAR_SINGLE && !$past(rst) && cnt_out != $past(cnt_out)
        |-> cnt_out == $past(cnt_out) + 16'h0001 || cnt_out == 16'h0000)
        else $error("single variant counted down");
endmodule
bind gpt_top gpt_top_checker #(.VARIANT(VARIANT)) gpt_top_checker_i (.core_clk(core_clk),
    .rst(rst), .ce(ce), .cnt_en(cnt_en), .dbg_freeze_en(dbg_freeze_en), .dbg_halt(dbg_halt),
    .dma_en(dma_en), .arr_val(arr_val), .cnt_out(cnt_out), .ch_out(ch_out),
    .update_evt(update_evt), .dac_trig(dac_trig), .dma_req(dma_req));
`default_nettype wire

/* File: verif/tb_general_purpose_timer.sv */
// Testbench: all four variants side by side on shared inputs
`timescale 1ns/1ns
`default_nettype none
module tb_general_purpose_timer;
    import gpt_pkg::*;
    typedef struct {logic [15:0] psc; logic [15:0] arr; logic dn; logic [15:0] cmp;} gpt_row_t;
    // Prescale, reload, down, compare; any window of one period is alike
    gpt_row_t rows [4] = '{'{16'h0000, 16'h0007, 1'b0, 16'h0003},
        '{16'h0001, 16'h0004, 1'b1, 16'h0002}, '{16'h0002, 16'h0005, 1'b0, 16'h0006},
        '{16'h0000, 16'h0009, 1'b1, 16'h0000}};
    logic core_clk, rst, ce, cnt_en, dir_down, dbg_freeze_en, dbg_halt, dma_en;
    logic trig_in, step, back, enc_a, enc_b;
    logic [15:0] psc_val, arr_val;
    logic [2:0] hall_in;
    gpt_src_t src_sel;
    logic [63:0] ch_cmp;
    logic [7:0] ch_mode;
    logic [3:0] cap_pin;
    logic lse_in;
    logic [63:0] cap_out [4];
    logic [15:0] cnt_out [4];
    logic [15:0] s [4];
    logic [3:0] ch_out [4];
    logic upd [4], trg [4], dac [4], dma [4], hev [4];
    int n_upd [4], n_trg [4], n_dac [4], n_pwm [4], n_dma, n_hall, failures, checks, cyc, per;
    // One instance per variant
    for (genvar v = 0; v < 4; v++)
    begin : g_var
        gpt_top #(.VARIANT(2'(v))) gpt_top_i (.core_clk(core_clk), .rst(rst), .ce(ce),
            .cnt_en(cnt_en), .dir_down(dir_down), .psc_val(psc_val), .arr_val(arr_val),
            .src_sel(src_sel), .dbg_freeze_en(dbg_freeze_en), .dbg_halt(dbg_halt),
            .dma_en(dma_en), .ch_mode(ch_mode), .ch_cmp(ch_cmp), .lse_in(lse_in), .enc_a(enc_a),
            .enc_b(enc_b), .hall_in(hall_in), .cap_pin(cap_pin), .trig_in(trig_in),
            .cnt_out(cnt_out[v]), .ch_out(ch_out[v]), .cap_out(cap_out[v]), .update_evt(upd[v]),
            .trig_out(trg[v]), .dac_trig(dac[v]), .dma_req(dma[v]), .hall_evt(hev[v]));
    end
    gpt_enc_model gpt_enc_model_i (.core_clk(core_clk), .step(step), .back(back),
        .enc_a(enc_a), .enc_b(enc_b), .hall(hall_in));
    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Tallies of pulses and PWM level, plus the hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        n_dma += int'(dma[0] === 1'b1);
        n_hall += int'(hev[0] === 1'b1);
        for (int v = 0; v < 4; v++)
        begin
            n_upd[v] += int'(upd[v] === 1'b1);
            n_trg[v] += int'(trg[v] === 1'b1);
            n_dac[v] += int'(dac[v] === 1'b1);
            n_pwm[v] += int'(ch_out[v][0] === 1'b1);
        end
        if (cyc == 6000)
        begin
            failures++;
            give_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Cleared off the edge so the tally process never races it
    task automatic clear();
        @(negedge core_clk);
        n_dma = 0;
        n_hall = 0;
        n_upd = '{4{0}};
        n_trg = '{4{0}};
        n_dac = '{4{0}};
        n_pwm = '{4{0}};
    endtask
    task automatic move(input logic dir);
        tick(1);
        back <= dir;
        step <= 1'b1;
        tick(1);
        step <= 1'b0;
        tick(10);
    endtask
    // One pin high for eight cycles then low for seven, well past the pin latency
    task automatic pulse(input int which);
        tick(1);
        trig_in <= (which == 0);
        lse_in <= (which == 1);
        cap_pin <= {3'h0, which == 2};
        tick(8);
        {trig_in, lse_in, cap_pin} <= 6'h00;
        tick(7);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        {rst, ce, cnt_en, dir_down, dbg_freeze_en, dbg_halt, dma_en, trig_in, step, back} = 10'h380;
        psc_val = 16'h0000;
        arr_val = 16'hFFFF;
        src_sel = GPT_SRC_INT;
        ch_cmp = 64'h0;
        ch_mode = 8'hAA;
        cap_pin = 4'h0;
        lse_in = 1'b0;
        tick(3);
        rst <= 1'b0;
        @(negedge core_clk);
        for (int v = 0; v < 4; v++)
            check(cnt_out[v], 16'h0000);
        foreach (rows[i])
        begin
            tick(1);
            dma_en <= 1'b1;
            psc_val <= rows[i].psc;
            arr_val <= rows[i].arr;
            dir_down <= rows[i].dn;
            ch_cmp <= {4{rows[i].cmp}};
            per = (int'(rows[i].arr) + 1) * (int'(rows[i].psc) + 1);
            tick(2 * per + 8);
            clear();
            tick(3 * per);
            @(negedge core_clk);
            check(16'(n_dma >= 3), 16'h0001);
            for (int v = 0; v < 4; v++)
            begin
                check(16'(n_upd[v]), 16'h0003);
                check(16'(n_trg[v]), 16'h0003);
                check(16'(n_dac[v]), (v == 3) ? 16'h0003 : 16'h0000);
                check(16'(n_pwm[v]), (v == 3) ? 16'h0000 : 16'(3 * per / (int'(rows[i].arr) + 1)
                    * int'(rows[i].cmp)));
            end
        end
        // Debug halt, clock enable and counter enable each freeze the count
        for (int k = 0; k < 3; k++)
        begin
            tick(1);
            arr_val <= 16'hFFFF;
            dir_down <= 1'b0;
            dbg_freeze_en <= (k == 0);
            dbg_halt <= (k == 0);
            ce <= (k != 1);
            cnt_en <= (k != 2);
            tick(4);
            @(negedge core_clk);
            s[0] = cnt_out[0];
            tick(10);
            @(negedge core_clk);
            check(cnt_out[0], s[0]);
        end
        tick(1);
        {dbg_freeze_en, dbg_halt, ce, cnt_en} <= 4'h3;
        src_sel <= GPT_SRC_ENC;
        tick(4);
        clear();
        s[0] = cnt_out[0];
        repeat (4) move(1'b0);
        @(negedge core_clk);
        check(16'(cnt_out[0] != s[0]), 16'h0001);
        repeat (4) move(1'b1);
        @(negedge core_clk);
        check(cnt_out[0], s[0]);
        check(16'(n_hall != 0), 16'h0001);
        tick(1);
        src_sel <= GPT_SRC_TRG;
        tick(4);
        @(negedge core_clk);
        s = cnt_out;
        repeat (4) pulse(0);
        tick(8);
        @(negedge core_clk);
        for (int v = 0; v < 4; v++)
            check(cnt_out[v], s[v] + 16'h0004);
        // Mid-run reset, then two trigger steps, one capture and three low-speed clock steps
        tick(1);
        rst <= 1'b1;
        ch_mode <= 8'h30;
        ch_cmp <= {4{16'h0001}};
        tick(3);
        rst <= 1'b0;
        @(negedge core_clk);
        for (int v = 0; v < 4; v++)
        begin
            check(cnt_out[v], 16'h0000);
            check(cap_out[v][15:0], 16'h0000);
        end
        repeat (2) pulse(0);
        tick(8);
        @(negedge core_clk);
        check(16'(ch_out[0][2]), 16'h0001);
        clear();
        pulse(2);
        tick(8);
        @(negedge core_clk);
        check(16'(n_dma != 0), 16'h0001);
        for (int v = 0; v < 4; v++)
            check(cap_out[v][15:0], (v == 3) ? 16'h0000 : 16'h0002);
        tick(1);
        src_sel <= GPT_SRC_LSE;
        repeat (3) pulse(1);
        tick(8);
        @(negedge core_clk);
        for (int v = 0; v < 4; v++)
            check(cnt_out[v], (v == 0) ? 16'h0002 : 16'h0005);
        give_verdict();
    end
endmodule
`default_nettype wire
